// ---- include/charge_cfg_pkg.sv ----
/*
 * Package for the charger temperature-band configuration registers:
 * offsets, reset values, field positions, decode tables and the carriers.
 * Assumes one clock domain shared with the host register port.
 */
package charge_cfg_pkg;

	// register offsets
	localparam logic [7:0] BAND_B_CHARGE_CONFIG_OFS = 8'h06;
	localparam logic [7:0] BAND_C_CHARGE_CONFIG_OFS = 8'h07;

	// reset values
	localparam logic [7:0] BAND_B_CHARGE_CONFIG_RST = 8'h4B;
	localparam logic [7:0] BAND_C_CHARGE_CONFIG_RST = 8'hBF;

	// field layout, identical in both registers
	localparam int THRESH_LSB  = 5;
	localparam int THRESH_W    = 3;
	localparam int VOLT_LSB    = 3;
	localparam int VOLT_W      = 2;
	localparam int CURR_LSB    = 0;
	localparam int CURR_W      = 3;

	// threshold in degrees C, default thermistor network
	localparam logic signed [7:0] TEMP_DEGC [8] = '{
		8'hF6, 8'h00, 8'h0A, 8'h0F, 8'h28, 8'h2D, 8'h32, 8'h3C
	};

	// termination feedback voltage in millivolts
	localparam logic [11:0] TERM_MV [4] = '{12'h7D0, 12'h802, 12'h81B, 12'h834};

	// current limit counted in steps of 12.5 percent of programmed current
	localparam logic [3:0] CURR_ZERO = 4'h0;
	localparam logic [3:0] CURR_STEP = 4'h1;

	typedef struct packed {
		logic signed [7:0] thresh_degc;
		logic [11:0]       term_mv;
		logic [3:0]        curr_eighths;
	} band_set_t;

	typedef struct packed {
		logic [7:0] cfg_b;
		logic [7:0] cfg_c;
		logic [7:0] rdata;
		logic       rvalid;
		band_set_t  set_b;
		band_set_t  set_c;
	} cfg_state_t;

endpackage : charge_cfg_pkg

// ---- logic/band_decode.sv ----
/*
 * Decodes one band configuration byte into threshold, termination
 * voltage and fast-charge current limit. Purely combinational.
 */
module band_decode (
	input  wire logic [7:0]                cfg,
	output charge_cfg_pkg::band_set_t     set
);

	logic [2:0] thresh_code;
	logic [1:0] volt_code;
	logic [2:0] curr_code;

	always_comb begin
		thresh_code = cfg[charge_cfg_pkg::THRESH_LSB +: charge_cfg_pkg::THRESH_W];
		volt_code   = cfg[charge_cfg_pkg::VOLT_LSB +: charge_cfg_pkg::VOLT_W];
		curr_code   = cfg[charge_cfg_pkg::CURR_LSB +: charge_cfg_pkg::CURR_W];
		set.thresh_degc = charge_cfg_pkg::TEMP_DEGC[thresh_code];
		set.term_mv     = charge_cfg_pkg::TERM_MV[volt_code];
		// code 0 is no current, then 25 percent rising by 12.5 percent
		if (curr_code == 3'h0) begin
			set.curr_eighths = charge_cfg_pkg::CURR_ZERO;
		end else begin
			set.curr_eighths = {1'b0, curr_code} + charge_cfg_pkg::CURR_STEP;
		end
	end

endmodule : band_decode

// ---- logic/charge_band_regs.sv ----
/*
 * Two read/write charger configuration registers for the second and third
 * temperature bands, with registered decoded settings for the charger.
 * Assumes the host register port runs on MCLK and drives one access a cycle.
 */
module charge_band_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic                       MCLK,
	input  wire logic                       RSTN,
	input  wire logic                       REG_WE,
	input  wire logic                       REG_RE,
	input  wire logic [ADDR_W-1:0]          REG_ADDR,
	input  wire logic [7:0]                 REG_WDATA,
	output logic [7:0]                      REG_RDATA,
	output logic                            REG_RVALID,
	output charge_cfg_pkg::band_set_t       BAND_B_SET,
	output charge_cfg_pkg::band_set_t       BAND_C_SET
);

	generate
		if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_width
			$error("ADDR_W must be between 3 and 8");
		end
	endgenerate

	localparam logic [ADDR_W-1:0] ADDR_B = ADDR_W'(charge_cfg_pkg::BAND_B_CHARGE_CONFIG_OFS);
	localparam logic [ADDR_W-1:0] ADDR_C = ADDR_W'(charge_cfg_pkg::BAND_C_CHARGE_CONFIG_OFS);

	charge_cfg_pkg::cfg_state_t state_r;
	charge_cfg_pkg::cfg_state_t state_nxt;
	charge_cfg_pkg::band_set_t  dec_b;
	charge_cfg_pkg::band_set_t  dec_c;

	logic hit_b;
	logic hit_c;

	assign hit_b = (REG_ADDR == ADDR_B);
	assign hit_c = (REG_ADDR == ADDR_C);

	band_decode u_decode_b (
		.cfg (state_r.cfg_b),
		.set (dec_b)
	);

	band_decode u_decode_c (
		.cfg (state_r.cfg_c),
		.set (dec_c)
	);

	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = REG_RE;
		// reads return the value held before a same-cycle write
		if (REG_RE) begin
			if (hit_b) begin
				state_nxt.rdata = state_r.cfg_b;
			end else if (hit_c) begin
				state_nxt.rdata = state_r.cfg_c;
			end else begin
				state_nxt.rdata = 8'h00;
			end
		end
		if (REG_WE && hit_b) begin
			state_nxt.cfg_b = REG_WDATA;
		end
		if (REG_WE && hit_c) begin
			state_nxt.cfg_c = REG_WDATA;
		end
		// decoded settings follow the stored bytes with no extra command
		state_nxt.set_b = dec_b;
		state_nxt.set_c = dec_c;
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r.cfg_b  <= charge_cfg_pkg::BAND_B_CHARGE_CONFIG_RST;
			state_r.cfg_c  <= charge_cfg_pkg::BAND_C_CHARGE_CONFIG_RST;
			state_r.rdata  <= 8'h00;
			state_r.rvalid <= 1'b0;
			state_r.set_b  <= '0;
			state_r.set_c  <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign REG_RDATA  = state_r.rdata;
	assign REG_RVALID = state_r.rvalid;
	assign BAND_B_SET = state_r.set_b;
	assign BAND_C_SET = state_r.set_c;

	// checks

	// port fields of the write and read bytes, for the checks below
	logic [2:0] wr_thresh;
	logic [1:0] wr_volt;
	logic [2:0] wr_curr;
	logic [3:0] wr_eighths;

	logic [2:0] rd_thresh;
	logic [1:0] rd_volt;
	logic [2:0] rd_curr;
	logic [3:0] rd_eighths;

	assign wr_thresh  = REG_WDATA[charge_cfg_pkg::THRESH_LSB +: charge_cfg_pkg::THRESH_W];
	assign wr_volt    = REG_WDATA[charge_cfg_pkg::VOLT_LSB +: charge_cfg_pkg::VOLT_W];
	assign wr_curr    = REG_WDATA[charge_cfg_pkg::CURR_LSB +: charge_cfg_pkg::CURR_W];
	assign wr_eighths = {1'b0, wr_curr} + {3'h0, (wr_curr != 3'h0)};

	assign rd_thresh  = REG_RDATA[charge_cfg_pkg::THRESH_LSB +: charge_cfg_pkg::THRESH_W];
	assign rd_volt    = REG_RDATA[charge_cfg_pkg::VOLT_LSB +: charge_cfg_pkg::VOLT_W];
	assign rd_curr    = REG_RDATA[charge_cfg_pkg::CURR_LSB +: charge_cfg_pkg::CURR_W];
	assign rd_eighths = {1'b0, rd_curr} + {3'h0, (rd_curr != 3'h0)};

	default clocking cb @(posedge MCLK);
	endclocking

	default disable iff (!RSTN);

	// a write shows on the decoded outputs one edge after the edge that takes it
	a_thresh_b_decode: assert property (
		(REG_WE && hit_b) |-> ##2
		BAND_B_SET.thresh_degc == charge_cfg_pkg::TEMP_DEGC[$past(wr_thresh, 2)]
	) else $error("band B threshold does not follow written code");

	a_volt_b_decode: assert property (
		(REG_WE && hit_b) |-> ##2
		BAND_B_SET.term_mv == charge_cfg_pkg::TERM_MV[$past(wr_volt, 2)]
	) else $error("band B termination voltage wrong");

	a_curr_b_decode: assert property (
		(REG_WE && hit_b) |-> ##2
		BAND_B_SET.curr_eighths == $past(wr_eighths, 2)
	) else $error("band B current limit wrong");

	a_thresh_c_decode: assert property (
		(REG_WE && hit_c) |-> ##2
		BAND_C_SET.thresh_degc == charge_cfg_pkg::TEMP_DEGC[$past(wr_thresh, 2)]
	) else $error("band C threshold does not follow written code");

	a_volt_c_decode: assert property (
		(REG_WE && hit_c) |-> ##2
		BAND_C_SET.term_mv == charge_cfg_pkg::TERM_MV[$past(wr_volt, 2)]
	) else $error("band C termination voltage wrong");

	a_curr_c_decode: assert property (
		(REG_WE && hit_c) |-> ##2
		BAND_C_SET.curr_eighths == $past(wr_eighths, 2)
	) else $error("band C current limit wrong");

	a_readback_b: assert property (
		(REG_WE && hit_b) ##1 (REG_RE && hit_b) |=>
		REG_RVALID && REG_RDATA == $past(REG_WDATA, 2)
	) else $error("band B read does not return last write");

	a_readback_c: assert property (
		(REG_WE && hit_c) ##1 (REG_RE && hit_c) |=>
		REG_RVALID && REG_RDATA == $past(REG_WDATA, 2)
	) else $error("band C read does not return last write");

	a_unmapped_read: assert property (
		(REG_RE && !hit_b && !hit_c) |=> REG_RVALID && REG_RDATA == 8'h00
	) else $error("unmapped read not zero");

	a_hold_idle: assert property (
		!REG_WE [*2] |=> $stable(BAND_B_SET) && $stable(BAND_C_SET)
	) else $error("settings changed without a write");

	// read strobe answers one edge later, data stands until the next read
	a_rvalid_pulse: assert property (
		REG_RE |=>
		REG_RVALID
	) else $error("read strobe not answered");

	a_rvalid_quiet: assert property (
		!REG_RE |=>
		!REG_RVALID
	) else $error("read valid without a read strobe");

	a_rdata_hold: assert property (
		!REG_RE |=>
		$stable(REG_RDATA)
	) else $error("read data changed without a read");

	// apart from reset and the first edge after it, a band moves only after a write to its own register
	a_b_hold_other: assert property (
		!(REG_WE && hit_b) |-> ##2
		$stable(BAND_B_SET)
	) else $error("band B settings moved without a band B write");

	a_c_hold_other: assert property (
		!(REG_WE && hit_c) |-> ##2
		$stable(BAND_C_SET)
	) else $error("band C settings moved without a band C write");

	a_unmapped_quiet: assert property (
		(REG_WE && !hit_b && !hit_c) |-> ##2
		$stable(BAND_B_SET) && $stable(BAND_C_SET)
	) else $error("unmapped write moved a band setting");

	// applied settings always agree with the byte that reads back
	a_read_match_b: assert property (
		(REG_RE && hit_b) |=>
		BAND_B_SET.thresh_degc == charge_cfg_pkg::TEMP_DEGC[rd_thresh]
		&& BAND_B_SET.term_mv == charge_cfg_pkg::TERM_MV[rd_volt]
		&& BAND_B_SET.curr_eighths == rd_eighths
	) else $error("band B settings disagree with its read-back byte");

	a_read_match_c: assert property (
		(REG_RE && hit_c) |=>
		BAND_C_SET.thresh_degc == charge_cfg_pkg::TEMP_DEGC[rd_thresh]
		&& BAND_C_SET.term_mv == charge_cfg_pkg::TERM_MV[rd_volt]
		&& BAND_C_SET.curr_eighths == rd_eighths
	) else $error("band C settings disagree with its read-back byte");

endmodule : charge_band_regs

// ---- testbench/test_charge_band_regs.sv ----
/* Self-checking bench for charge_band_regs: reset values, field decode and
   its latency, read-back, unmapped and same-cycle accesses, mid-run reset.
   Assumes charge_cfg_pkg is compiled first. */
module test_charge_band_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      MCLK = 1'b0;
	logic                      RSTN = 1'b0;
	logic                      REG_WE = 1'b0;
	logic                      REG_RE = 1'b0;
	logic [7:0]                REG_ADDR = 8'h00;
	logic [7:0]                REG_WDATA = 8'h00;
	logic [7:0]                REG_RDATA;
	logic                      REG_RVALID;
	charge_cfg_pkg::band_set_t BAND_B_SET;
	charge_cfg_pkg::band_set_t BAND_C_SET;
	int                        errors = 0;
	int                        checks = 0;
	localparam logic [7:0]  DEGC [8] = '{8'hF6, 8'h00, 8'h0A, 8'h0F, 8'h28, 8'h2D, 8'h32, 8'h3C};
	localparam logic [11:0] MV [4]   = '{12'h7D0, 12'h802, 12'h81B, 12'h834};

	always #2.5 MCLK = ~MCLK;

	charge_band_regs #(.ADDR_W(8)) u_dut (
		.MCLK(MCLK), .RSTN(RSTN), .REG_WE(REG_WE), .REG_RE(REG_RE),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .BAND_B_SET(BAND_B_SET), .BAND_C_SET(BAND_C_SET)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		checks++;
		if (seen !== expd) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	// threshold, millivolts, eighths of programmed current
	function automatic logic [23:0] decode(input logic [7:0] v);
		logic [3:0] cur;
		cur = (v[2:0] == 3'h0) ? 4'h0 : {1'b0, v[2:0]} + 4'h1;
		return {DEGC[v[7:5]], MV[v[4:3]], cur};
	endfunction : decode

	// strobe held; caller drops it
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		REG_WE = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		@(negedge MCLK);
	endtask : write_reg

	task automatic read_expect(input logic [7:0] a, input logic [7:0] expd);
		REG_RE = 1'b1;
		REG_ADDR = a;
		@(negedge MCLK);
		REG_RE = 1'b0;
		check({31'h0, REG_RVALID}, 32'h1);
		check({24'h0, REG_RDATA}, {24'h0, expd});
		@(negedge MCLK);
		check({31'h0, REG_RVALID}, 32'h0);
		check({24'h0, REG_RDATA}, {24'h0, expd});
	endtask : read_expect

	task automatic test_reset();
		read_expect(8'h06, 8'h4B);
		read_expect(8'h07, 8'hBF);
		check({8'h00, BAND_B_SET}, {8'h00, decode(8'h4B)});
		check({8'h00, BAND_C_SET}, {8'h00, decode(8'hBF)});
		$display("test_reset done");
	endtask : test_reset

	task automatic test_sweep();
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] pb;
		logic [7:0] pc;
		pb = 8'h4B;
		pc = 8'hBF;
		for (int i = 0; i < 8; i++) begin
			b = {i[2:0], i[1:0], i[2:0]};
			c = ~b;
			write_reg(8'h06, b);
			check({8'h00, BAND_B_SET}, {8'h00, decode(pb)});
			write_reg(8'h07, c);
			REG_WE = 1'b0;
			check({8'h00, BAND_B_SET}, {8'h00, decode(b)});
			check({8'h00, BAND_C_SET}, {8'h00, decode(pc)});
			@(negedge MCLK);
			check({8'h00, BAND_C_SET}, {8'h00, decode(c)});
			read_expect(8'h06, b);
			read_expect(8'h07, c);
			pb = b;
			pc = c;
		end
		$display("test_sweep done");
	endtask : test_sweep

	// the sweep leaves 0xFF at offset 0x06 and 0x00 at offset 0x07
	task automatic test_edges();
		write_reg(8'h08, 8'h33);
		write_reg(8'h05, 8'h33);
		REG_WE = 1'b0;
		@(negedge MCLK);
		read_expect(8'h08, 8'h00);
		read_expect(8'h05, 8'h00);
		read_expect(8'h06, 8'hFF);
		read_expect(8'h07, 8'h00);
		check({8'h00, BAND_B_SET}, {8'h00, decode(8'hFF)});
		check({8'h00, BAND_C_SET}, {8'h00, decode(8'h00)});
		REG_WE = 1'b1;
		REG_RE = 1'b1;
		REG_ADDR = 8'h06;
		REG_WDATA = 8'h5A;
		@(negedge MCLK);
		REG_WE = 1'b0;
		REG_RE = 1'b0;
		check({31'h0, REG_RVALID}, 32'h1);
		check({24'h0, REG_RDATA}, 32'h000000FF);
		@(negedge MCLK);
		read_expect(8'h06, 8'h5A);
		read_expect(8'h07, 8'h00);
		check({8'h00, BAND_B_SET}, {8'h00, decode(8'h5A)});
		$display("test_edges done");
	endtask : test_edges

	task automatic test_mid_reset();
		write_reg(8'h06, 8'h21);
		write_reg(8'h07, 8'h12);
		REG_WE = 1'b0;
		@(negedge MCLK);
		read_expect(8'h07, 8'h12);
		RSTN = 1'b0;
		@(negedge MCLK);
		check({8'h00, BAND_B_SET}, 32'h0);
		check({8'h00, BAND_C_SET}, 32'h0);
		check({24'h0, REG_RDATA}, 32'h0);
		check({31'h0, REG_RVALID}, 32'h0);
		RSTN = 1'b1;
		@(negedge MCLK);
		check({8'h00, BAND_B_SET}, {8'h00, decode(8'h4B)});
		check({8'h00, BAND_C_SET}, {8'h00, decode(8'hBF)});
		read_expect(8'h06, 8'h4B);
		read_expect(8'h07, 8'hBF);
		$display("test_mid_reset done");
	endtask : test_mid_reset

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20) @(negedge MCLK);
		RSTN = 1'b1;
		@(negedge MCLK);
		test_reset();
		test_sweep();
		test_edges();
		test_mid_reset();
		give_verdict();
	end
endmodule : test_charge_band_regs
